/* File: inc/ibhc_pkg.sv */
package ibhc_pkg;
    localparam logic [7:0] ADDR_ICACHE_STATUS = 8'hD3;
    localparam logic [7:0] ADDR_BRANCH_CTRL = 8'hD4;
    localparam int ICS_TAG_PERR_BIT = 4;
    localparam int ICS_DATA_PERR_BIT = 3;
    localparam int ICS_LOCK_BIT = 2;
    localparam int ICS_ENABLE_BIT = 0;
    localparam int BPC_ALG_LSB = 16;
    localparam int BPC_LOAD_BIT = 8;
    localparam int BPC_CTR_RESET_BIT = 7;
    localparam int BPC_FLUSH_BIT = 6;
    localparam int BPC_MISPREDICT_BIT = 5;
    localparam int HIST_W = 4;
    localparam int CTR_W = 9;
    localparam int TABLE_DEPTH = 512;
    localparam logic [3:0] HIST_NEUTRAL = 4'h4;
    localparam logic [15:0] ALG_RESET = 16'h0000;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ibhc_ipr_req_t;

    typedef struct packed {
        logic tag_err;
        logic data_err;
        logic [31:0] vaddr;
    } ibhc_perr_t;

    typedef struct packed {
        logic valid;
        logic [CTR_W-1:0] index;
        logic taken;
        logic predicted;
    } ibhc_resolve_t;
endpackage : ibhc_pkg

/* File: hw/ibhc_history_table.sv */
`timescale 1ns/10ps
`default_nettype none
module ibhc_history_table
    import ibhc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic wr_en,
    input wire logic [CTR_W-1:0] wr_idx,
    input wire logic [HIST_W-1:0] wr_data,
    input wire logic upd_en,
    input wire logic [CTR_W-1:0] upd_idx,
    input wire logic upd_taken,
    input wire logic [CTR_W-1:0] rd_idx,
    output logic [HIST_W-1:0] rd_hist,
    input wire logic [CTR_W-1:0] lk_idx,
    output logic [HIST_W-1:0] lk_hist
);
    typedef struct packed {
        logic [TABLE_DEPTH-1:0][HIST_W-1:0] entry;
    } ibhc_tbl_state_t;

    ibhc_tbl_state_t state;
    ibhc_tbl_state_t next_state;

    always_comb begin
        next_state = state;
        // Flush first so a same-cycle write lands on top of the neutral value
        if (flush) begin
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                next_state.entry[i] = HIST_NEUTRAL;
            end
        end
        if (upd_en) begin
            next_state.entry[upd_idx] = {next_state.entry[upd_idx][HIST_W-2:0], upd_taken};
        end
        // Software load wins over a branch update to the same entry
        if (wr_en) begin
            next_state.entry[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '{entry: {TABLE_DEPTH{HIST_NEUTRAL}}};
        end else begin
            state <= next_state;
        end
    end

    assign rd_hist = state.entry[rd_idx];
    assign lk_hist = state.entry[lk_idx];
endmodule : ibhc_history_table
`default_nettype wire

/* File: hw/ibhc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ibhc_top
    import ibhc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire ibhc_ipr_req_t ipr_req,
    output logic [31:0] ipr_rdata,
    output logic ipr_rvalid,
    input wire ibhc_perr_t perr,
    input wire logic context_switch,
    input wire logic pred_req,
    input wire logic [CTR_W-1:0] pred_idx,
    output logic pred_valid,
    output logic pred_taken,
    input wire ibhc_resolve_t resolve,
    output logic cache_access_enable,
    output logic [31:0] cache_address_reg
);
    typedef struct packed {
        logic tag_perr;
        logic data_perr;
        logic lock;
        logic access_enable;
        logic [31:0] err_addr;
        logic [15:0] algorithm;
        logic [CTR_W-1:0] counter;
        logic mispredict;
        logic [31:0] rdata;
        logic rvalid;
        logic pvalid;
        logic ptaken;
    } ibhc_state_t;

    ibhc_state_t state;
    ibhc_state_t next_state;

    logic wr_ics;
    logic wr_bpc;
    logic rd_ics;
    logic rd_bpc;
    logic load_hist;
    logic flush_tbl;
    logic err_any;
    logic lock_clear;
    logic [HIST_W-1:0] rd_hist;
    logic [HIST_W-1:0] lk_hist;

    function automatic logic hit(input ibhc_ipr_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction : hit

    assign wr_ics = ipr_req.wr && hit(ipr_req, ADDR_ICACHE_STATUS);
    assign wr_bpc = ipr_req.wr && hit(ipr_req, ADDR_BRANCH_CTRL);
    assign rd_ics = ipr_req.rd && hit(ipr_req, ADDR_ICACHE_STATUS);
    assign rd_bpc = ipr_req.rd && hit(ipr_req, ADDR_BRANCH_CTRL);

    // Bits 8:6 act independently; this yields every write code, defined or not
    assign load_hist = wr_bpc && ipr_req.wdata[BPC_LOAD_BIT];
    assign flush_tbl = (wr_bpc && ipr_req.wdata[BPC_FLUSH_BIT]) || context_switch;
    assign err_any = perr.tag_err || perr.data_err;
    assign lock_clear = wr_ics && ipr_req.wdata[ICS_LOCK_BIT];

    ibhc_history_table u_table (
        .clk(clk),
        .reset_n(reset_n),
        .flush(flush_tbl),
        .wr_en(load_hist),
        .wr_idx(state.counter),
        .wr_data(ipr_req.wdata[HIST_W-1:0]),
        .upd_en(resolve.valid),
        .upd_idx(resolve.index),
        .upd_taken(resolve.taken),
        .rd_idx(state.counter),
        .rd_hist(rd_hist),
        .lk_idx(pred_idx),
        .lk_hist(lk_hist)
    );

    always_comb begin
        next_state = state;
        next_state.rvalid = ipr_req.rd;
        next_state.pvalid = pred_req;

        // Error capture: the lock freezes flags and address until cleared
        if (lock_clear) begin
            next_state.lock = 1'b0;
            next_state.tag_perr = 1'b0;
            next_state.data_perr = 1'b0;
        end
        // An error in the clearing cycle is kept: set wins over clear
        if (err_any && (!state.lock || lock_clear)) begin
            next_state.tag_perr = perr.tag_err;
            next_state.data_perr = perr.data_err;
            next_state.lock = 1'b1;
            next_state.err_addr = perr.vaddr;
        end
        if (wr_ics) begin
            next_state.access_enable = ipr_req.wdata[ICS_ENABLE_BIT];
        end

        if (wr_bpc) begin
            next_state.algorithm = ipr_req.wdata[31:BPC_ALG_LSB];
        end
        // Counter reset beats the increment, so codes 110 and 111 write at the old value
        if (wr_bpc && ipr_req.wdata[BPC_CTR_RESET_BIT]) begin
            next_state.counter = '0;
        end else if (rd_bpc || load_hist) begin
            next_state.counter = state.counter + CTR_W'(1);
        end

        if (resolve.valid) begin
            next_state.mispredict = resolve.taken != resolve.predicted;
        end

        next_state.ptaken = state.algorithm[lk_hist];

        next_state.rdata = '0;
        if (rd_ics) begin
            next_state.rdata[ICS_TAG_PERR_BIT] = state.tag_perr;
            next_state.rdata[ICS_DATA_PERR_BIT] = state.data_perr;
            next_state.rdata[ICS_LOCK_BIT] = state.lock;
            next_state.rdata[ICS_ENABLE_BIT] = state.access_enable;
        end else if (rd_bpc) begin
            next_state.rdata[31:BPC_ALG_LSB] = state.algorithm;
            next_state.rdata[BPC_MISPREDICT_BIT] = state.mispredict;
            next_state.rdata[HIST_W-1:0] = rd_hist;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '{
                tag_perr: 1'b0,
                data_perr: 1'b0,
                lock: 1'b0,
                access_enable: 1'b0,
                err_addr: 32'h0000_0000,
                algorithm: ALG_RESET,
                counter: '0,
                mispredict: 1'b0,
                rdata: 32'h0000_0000,
                rvalid: 1'b0,
                pvalid: 1'b0,
                ptaken: 1'b0
            };
        end else begin
            state <= next_state;
        end
    end

    assign ipr_rdata = state.rdata;
    assign ipr_rvalid = state.rvalid;
    assign pred_valid = state.pvalid;
    assign pred_taken = state.ptaken;
    assign cache_access_enable = state.access_enable;
    assign cache_address_reg = state.err_addr;
endmodule : ibhc_top
`default_nettype wire

/* File: verif/ibhc_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module ibhc_chk
    import ibhc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire ibhc_ipr_req_t ipr_req,
    input wire logic [31:0] ipr_rdata,
    input wire logic ipr_rvalid,
    input wire ibhc_perr_t perr,
    input wire logic pred_req,
    input wire logic pred_valid,
    input wire logic cache_access_enable,
    input wire logic [31:0] cache_address_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic st_wr, b_wr, b_rd, um_rd;
    assign st_wr = ipr_req.wr && ipr_req.addr == ADDR_ICACHE_STATUS;
    assign b_wr = ipr_req.wr && ipr_req.addr == ADDR_BRANCH_CTRL;
    assign b_rd = ipr_req.rd && ipr_req.addr == ADDR_BRANCH_CTRL;
    assign um_rd = ipr_req.rd && !b_rd && ipr_req.addr != ADDR_ICACHE_STATUS;
    property p_rv; ipr_req.rd |=> ipr_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_norv; !ipr_req.rd |=> !ipr_rvalid && ipr_rdata == 32'h0; endproperty
    a_norv: assert property (p_norv) else $error("stray read answer");
    property p_pv; pred_req |=> pred_valid; endproperty
    a_pv: assert property (p_pv) else $error("lookup not answered");
    property p_npv; !pred_req |=> !pred_valid; endproperty
    a_npv: assert property (p_npv) else $error("stray lookup answer");
    property p_en; st_wr |=> cache_access_enable == $past(ipr_req.wdata[0]); endproperty
    a_en: assert property (p_en) else $error("enable not written");
    property p_ens; !st_wr |=> $stable(cache_access_enable); endproperty
    a_ens: assert property (p_ens) else $error("enable moved alone");
    property p_adr; !(perr.tag_err || perr.data_err) |=> $stable(cache_address_reg); endproperty
    a_adr: assert property (p_adr) else $error("address moved without error");
    property p_bz; b_rd |=> ipr_rdata[8:6] == 3'h0 && !ipr_rdata[4]; endproperty
    a_bz: assert property (p_bz) else $error("control bits read back");
    // Write tasks leave one idle cycle, so the read follows two edges later
    property p_alg; b_wr ##2 b_rd |=> ipr_rdata[31:16] == $past(ipr_req.wdata[31:16], 3);
    endproperty
    a_alg: assert property (p_alg) else $error("algorithm not returned");
    property p_um; um_rd |=> ipr_rdata == 32'h0; endproperty
    a_um: assert property (p_um) else $error("unmapped read not zero");
endmodule : ibhc_chk
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ibhc_pkg::*;
    logic clk, reset_n, cs, preq, ptk, pv, rv, en;
    logic [CTR_W-1:0] pidx;
    logic [31:0] rdat, vreg, d;
    logic [15:0] alg;
    ibhc_ipr_req_t req;
    ibhc_perr_t perr;
    ibhc_resolve_t res;
    int n_fail, checks;
    ibhc_top uut (.clk(clk), .reset_n(reset_n), .ipr_req(req), .ipr_rdata(rdat),
        .ipr_rvalid(rv), .perr(perr), .context_switch(cs), .pred_req(preq), .pred_idx(pidx),
        .pred_valid(pv), .pred_taken(ptk), .resolve(res), .cache_access_enable(en),
        .cache_address_reg(vreg));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        req = '{1'b0, 1'b1, a, v};
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        req = '{1'b1, 1'b0, a, 32'h0};
        @(negedge clk);
        req.rd = 1'b0;
        d = rdat;
        cmp({31'h0, rv}, 32'h1);
        @(negedge clk);
    endtask : rd
    task automatic bw(input logic [2:0] c, input logic [3:0] h);
        wr(ADDR_BRANCH_CTRL, {alg, 7'h0, c, 2'h0, h});
    endtask : bw
    task automatic br(input logic [3:0] h, input logic m);
        rd(ADDR_BRANCH_CTRL);
        cmp(d, {alg, 10'h0, m, 1'b0, h});
    endtask : br
    task automatic pe(input logic t, input logic e, input logic [31:0] a, input logic [31:0] s);
        perr = '{t, e, a};
        @(negedge clk);
        perr = '0;
        rd(ADDR_ICACHE_STATUS);
        cmp(d, s);
    endtask : pe
    task automatic s_hist;
        alg = 16'hA5A5;
        bw(3'h2, 4'h0);
        for (int i = 0; i < 4; i++) bw(3'h4, 4'(i * 3 + 1));
        bw(3'h2, 4'h0);
        for (int i = 0; i < 4; i++) br(4'(i * 3 + 1), 1'b0);
        br(HIST_NEUTRAL, 1'b0);
        rd(8'h00);
        cmp(d, 32'h0);
    endtask : s_hist
    task automatic s_flush;
        bw(3'h3, 4'h0);
        br(HIST_NEUTRAL, 1'b0);
        bw(3'h5, 4'h9);
        bw(3'h2, 4'h0);
        br(HIST_NEUTRAL, 1'b0);
        br(4'h9, 1'b0);
        cs = 1'b1;
        @(negedge clk);
        cs = 1'b0;
        bw(3'h2, 4'h0);
        br(HIST_NEUTRAL, 1'b0);
        br(HIST_NEUTRAL, 1'b0);
    endtask : s_flush
    task automatic s_wrap;
        // Park the counter at zero so the 110 load lands on entry zero
        bw(3'h2, 4'h0);
        bw(3'h6, 4'h7);
        for (int i = 0; i < TABLE_DEPTH; i++) rd(ADDR_BRANCH_CTRL);
        br(4'h7, 1'b0);
        bw(3'h7, 4'h2);
        br(HIST_NEUTRAL, 1'b0);
        br(4'h2, 1'b0);
    endtask : s_wrap
    task automatic s_pred;
        alg = 16'h0020;
        bw(3'h2, 4'h0);
        bw(3'h4, 4'h5);
        bw(3'h4, 4'h0);
        bw(3'h0, 4'h0);
        for (int i = 0; i < 2; i++) begin
            preq = 1'b1;
            pidx = 9'(i);
            @(negedge clk);
            preq = 1'b0;
            cmp({31'h0, ptk}, 32'(i == 0));
            @(negedge clk);
        end
        for (int i = 0; i < 2; i++) begin
            res = '{1'b1, 9'h1FF, 1'b1, 1'(i)};
            @(negedge clk);
            res = '0;
            bw(3'h2, 4'h0);
            br(4'h5, 1'(1 - i));
        end
    endtask : s_pred
    task automatic s_perr;
        rd(ADDR_ICACHE_STATUS);
        cmp(d, 32'h0);
        wr(ADDR_ICACHE_STATUS, 32'h1);
        cmp({31'h0, en}, 32'h1);
        pe(1'b1, 1'b0, 32'hA, 32'h15);
        pe(1'b0, 1'b1, 32'hB, 32'h15);
        cmp(vreg, 32'hA);
        wr(ADDR_ICACHE_STATUS, 32'h5);
        pe(1'b0, 1'b1, 32'hC, 32'h0D);
        cmp(vreg, 32'hC);
    endtask : s_perr
    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #250000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        {reset_n, cs, preq, pidx, alg, req, perr, res, n_fail, checks} = '0;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        s_perr();
        s_hist();
        s_flush();
        s_wrap();
        s_pred();
        report_and_stop();
    end
endmodule : testbench
bind ibhc_top ibhc_chk u_chk (.clk, .reset_n, .ipr_req, .ipr_rdata, .ipr_rvalid, .perr,
    .pred_req, .pred_valid, .cache_access_enable, .cache_address_reg);
`default_nettype wire
